// >>> rtl/bootl_params.svh
`ifndef BOOTL_PARAMS_SVH
`define BOOTL_PARAMS_SVH
// ****************************************
// Timing
// ****************************************
`define BOOTL_CLK_MHZ         25
`define BOOTL_RST_DELAY_US    15
`define BOOTL_RST_DELAY_CYC   ((`BOOTL_RST_DELAY_US * `BOOTL_CLK_MHZ) < 1 ? 1 : \
                               (`BOOTL_RST_DELAY_US * `BOOTL_CLK_MHZ))
// ****************************************
// Image constants
// ****************************************
`define BOOTL_NO_CRC_WORD     32'h0D15_AB1E
`define BOOTL_CRC_POLY        32'hEDB8_8320
`define BOOTL_CRC_PRESET      32'hFFFF_FFFF
`define BOOTL_SECURE_BIT      5
`define BOOTL_FLASH_CMD_READ  8'h03
`define BOOTL_START_ADDR      0
`endif

// >>> rtl/bootl_pkg.sv
package bootl_pkg;
    // Sequencer states, gray codes along the usual path
    typedef enum logic [3:0] {
        BOOTL_RESET   = 4'b0000,
        BOOTL_DELAY   = 4'b0001,
        BOOTL_CMD     = 4'b0011,
        BOOTL_LEN     = 4'b0010,
        BOOTL_PROG    = 4'b0110,
        BOOTL_CHECK   = 4'b0111,
        BOOTL_VERIFY  = 4'b0101,
        BOOTL_RUN     = 4'b0100,
        BOOTL_FAIL    = 4'b1100
    } bootl_state_e;
endpackage

// >>> rtl/bootl_loader.sv
`timescale 1ns/100ps
`include "bootl_params.svh"

module bootl_loader
    import bootl_pkg::*;
#(
    parameter int ADDR_W    = 15,
    parameter int DELAY_CYC = `BOOTL_RST_DELAY_CYC
) (
    input  wire logic              clk_i,         // Tile clock, 25 MHz
    input  wire logic              rst_b_i,       // Global reset pin, active low
    input  wire logic              ce_i,          // Clock enable, freezes state
    input  wire logic [31:0]       security_i,    // Security register value
    input  wire logic [31:0]       otp_data_i,    // OTP read data, valid in the same cycle as the read strobe
    output logic      [ADDR_W-1:0] otp_addr_o,    // OTP word address
    output logic                   otp_rd_o,      // OTP read strobe
    output logic                   spi_sck_o,     // Flash serial clock
    output logic                   spi_cs_b_o,    // Flash chip select, active low
    output logic      [3:0]        spi_dq_o,      // Flash data out
    output logic      [3:0]        spi_dq_oe_o,   // Flash data output enable
    input  wire logic [3:0]        spi_dq_i,      // Flash data in (pins)
    output logic                   ram_we_o,      // RAM byte write strobe
    output logic      [ADDR_W+1:0] ram_addr_o,    // RAM byte address
    output logic      [7:0]        ram_data_o,    // RAM write byte
    output logic                   core_rst_o,    // Tile held in reset
    output logic                   io_pulldown_o, // Pull-downs on all I/O pins
    output logic                   run_o,         // Program started
    output logic      [ADDR_W+1:0] start_addr_o,  // Execution start address
    output logic                   boot_fail_o    // CRC mismatch flag
);
    // ****************************************
    // CRC byte update
    // ****************************************
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `BOOTL_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [3:0] dq_s1_reg, dq_s2_reg;
    logic       rst_s1_reg, rst_s2_reg;
    always_ff @(posedge clk_i) begin
        dq_s1_reg  <= spi_dq_i;
        dq_s2_reg  <= dq_s1_reg;
        rst_s1_reg <= rst_b_i;
        rst_s2_reg <= rst_s1_reg;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    bootl_state_e      st_reg, st_next;
    logic [15:0]       cnt_reg, cnt_next;       // Delay / bit counter
    logic [31:0]       len_reg, len_next;       // Program length in words
    logic [31:0]       wcnt_reg, wcnt_next;     // Words stored
    logic [1:0]        bcnt_reg, bcnt_next;     // Byte within word
    logic [31:0]       chk_reg, chk_next;
    logic [31:0]       crc_reg, crc_next;
    logic [7:0]        sh_reg, sh_next;         // Flash byte shifter
    logic [2:0]        bit_reg, bit_next;
    logic              otp_reg, otp_next;       // Boot source is OTP
    logic              otpv_reg, otpv_next;     // OTP data valid next cycle
    logic [ADDR_W-1:0] oa_reg, oa_next;
    logic [ADDR_W+1:0] ra_reg, ra_next;
    logic              we_reg, we_next;
    logic [7:0]        wd_reg, wd_next;
    logic              sck_reg, sck_next, cs_reg, cs_next, mosi_reg, mosi_next;
    logic              byte_ok;
    logic [7:0]        in_byte;
    logic [31:0]       otp_word;
    logic [31:0]       otp_buf_reg, otp_buf_next;
    localparam logic [7:0] FLASH_CMD = `BOOTL_FLASH_CMD_READ; // Flash read opcode

    always_comb begin
        st_next = st_reg; cnt_next = cnt_reg; len_next = len_reg; wcnt_next = wcnt_reg;
        bcnt_next = bcnt_reg; chk_next = chk_reg; crc_next = crc_reg; sh_next = sh_reg;
        bit_next = bit_reg; otp_next = otp_reg; otpv_next = 1'b0; oa_next = oa_reg;
        ra_next = ra_reg; we_next = 1'b0; wd_next = wd_reg; sck_next = sck_reg;
        cs_next = cs_reg; mosi_next = mosi_reg; otp_buf_next = otp_buf_reg;
        byte_ok = 1'b0; in_byte = 8'h00; otp_word = otp_data_i;
        // Byte source: OTP word split LSB first, or flash shifter (MSB first on wire)
        if (otp_reg) begin
            if (otpv_reg) begin
                otp_buf_next = otp_word;
            end
        end
        case (st_reg)
            BOOTL_RESET: begin
                st_next = BOOTL_DELAY; cnt_next = 16'h0000;
            end
            BOOTL_DELAY: begin
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg == 16'(DELAY_CYC - 1)) begin
                    otp_next = security_i[`BOOTL_SECURE_BIT];
                    oa_next  = ADDR_W'(`BOOTL_START_ADDR);
                    crc_next = `BOOTL_CRC_PRESET;
                    ra_next  = (ADDR_W+2)'(`BOOTL_START_ADDR);
                    bcnt_next = 2'd0; wcnt_next = 32'h0000_0000;
                    cs_next = security_i[`BOOTL_SECURE_BIT];
                    // First command bit is set up a full cycle before the first rise
                    sh_next = {FLASH_CMD[6:0], 1'b0}; mosi_next = FLASH_CMD[7];
                    bit_next = 3'd0; cnt_next = 16'h0000;
                    st_next = security_i[`BOOTL_SECURE_BIT] ? BOOTL_LEN : BOOTL_CMD;
                    otpv_next = security_i[`BOOTL_SECURE_BIT];
                end
            end
            BOOTL_CMD: begin
                // Read command then 24 zero address bits; data moves as the clock falls
                sck_next = ~sck_reg;
                if (sck_reg) begin
                    mosi_next = (cnt_reg < 16'd7) ? sh_reg[7] : 1'b0;
                    sh_next = {sh_reg[6:0], 1'b0};
                    cnt_next = cnt_reg + 16'h0001;
                    if (cnt_reg == 16'd31) begin
                        st_next = BOOTL_LEN; cnt_next = 16'h0000;
                    end
                end
            end
            default: ;
        endcase
        // Byte reception for LEN/PROG/CHECK
        if (st_reg == BOOTL_LEN || st_reg == BOOTL_PROG || st_reg == BOOTL_CHECK) begin
            if (otp_reg) begin
                if (!otpv_reg && !otpv_next) begin
                    byte_ok = 1'b1;
                    in_byte = otp_buf_reg[8*bcnt_reg +: 8];
                end
            end else begin
                // Synchroniser delay equals two clk_i periods, one serial clock period, so the bit taken at a
                // rising edge shows up while the clock is low; the first low is skipped
                sck_next = ~sck_reg;
                if (sck_reg) begin
                    cnt_next = 16'h0001;
                end else if (cnt_reg != 16'h0000) begin
                    sh_next  = {sh_reg[6:0], dq_s2_reg[1]};
                    bit_next = bit_reg + 3'd1;
                    if (bit_reg == 3'd7) begin
                        byte_ok = 1'b1;
                        in_byte = {sh_reg[6:0], dq_s2_reg[1]};
                    end
                end
            end
        end
        if (byte_ok) begin
            bcnt_next = bcnt_reg + 2'd1;
            if (otp_reg && bcnt_reg == 2'd3) begin
                oa_next = oa_reg + ADDR_W'(1); otpv_next = 1'b1;
            end
            case (st_reg)
                BOOTL_LEN: begin
                    len_next = {in_byte, len_reg[31:8]};
                    crc_next = crc_byte(crc_reg, in_byte);
                    if (bcnt_reg == 2'd3) begin
                        st_next = ({in_byte, len_reg[31:8]} == 32'h0) ? BOOTL_CHECK
                                                                        : BOOTL_PROG;
                    end
                end
                BOOTL_PROG: begin
                    crc_next = crc_byte(crc_reg, in_byte);
                    we_next = 1'b1; wd_next = in_byte;
                    ra_next = ra_reg + (ADDR_W+2)'(1); // Next byte address
                    if (bcnt_reg == 2'd3) begin
                        wcnt_next = wcnt_reg + 32'h1;
                        if (wcnt_reg + 32'h1 == len_reg) st_next = BOOTL_CHECK;
                    end
                end
                default: begin
                    chk_next = {in_byte, chk_reg[31:8]};
                    if (bcnt_reg == 2'd3) st_next = BOOTL_VERIFY;
                end
            endcase
        end
        if (st_reg == BOOTL_VERIFY) begin
            cs_next = 1'b1; sck_next = 1'b0;
            if (chk_reg == `BOOTL_NO_CRC_WORD || chk_reg == ~crc_reg)
                st_next = BOOTL_RUN;
            else
                st_next = BOOTL_FAIL;
        end
        if (st_reg == BOOTL_RUN || st_reg == BOOTL_FAIL) begin
            cs_next = 1'b1; sck_next = 1'b0;
        end
    end

    // Registers; reset pin low forces the held state
    always_ff @(posedge clk_i) begin
        if (!rst_s2_reg) begin
            st_reg <= BOOTL_RESET; cnt_reg <= 16'h0000; len_reg <= 32'h0;
            wcnt_reg <= 32'h0; bcnt_reg <= 2'd0; chk_reg <= 32'h0;
            crc_reg <= `BOOTL_CRC_PRESET; sh_reg <= 8'h00; bit_reg <= 3'd0;
            otp_reg <= 1'b0; otpv_reg <= 1'b0; oa_reg <= '0; ra_reg <= '0;
            we_reg <= 1'b0; wd_reg <= 8'h00; sck_reg <= 1'b0; cs_reg <= 1'b1;
            mosi_reg <= 1'b0; otp_buf_reg <= 32'h0;
        end else if (ce_i) begin
            st_reg <= st_next; cnt_reg <= cnt_next; len_reg <= len_next;
            wcnt_reg <= wcnt_next; bcnt_reg <= bcnt_next; chk_reg <= chk_next;
            crc_reg <= crc_next; sh_reg <= sh_next; bit_reg <= bit_next;
            otp_reg <= otp_next; otpv_reg <= otpv_next; oa_reg <= oa_next;
            ra_reg <= ra_next; we_reg <= we_next; wd_reg <= wd_next;
            sck_reg <= sck_next; cs_reg <= cs_next; mosi_reg <= mosi_next;
            otp_buf_reg <= otp_buf_next;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_s2_reg) begin
            core_rst_o <= 1'b1; io_pulldown_o <= 1'b1; run_o <= 1'b0;
            boot_fail_o <= 1'b0; ram_we_o <= 1'b0; ram_addr_o <= '0; ram_data_o <= 8'h00;
            spi_sck_o <= 1'b0; spi_cs_b_o <= 1'b1; spi_dq_o <= 4'h0; spi_dq_oe_o <= 4'h0;
            otp_addr_o <= '0; otp_rd_o <= 1'b0; start_addr_o <= '0;
        end else if (ce_i) begin
            core_rst_o    <= (st_next != BOOTL_RUN);
            io_pulldown_o <= 1'b0;
            run_o         <= (st_next == BOOTL_RUN);
            boot_fail_o   <= (st_next == BOOTL_FAIL);
            start_addr_o  <= (ADDR_W+2)'(`BOOTL_START_ADDR);
            ram_we_o      <= we_next;
            ram_addr_o    <= ra_reg; // Address of the byte written now
            ram_data_o    <= wd_next;
            spi_sck_o     <= sck_next;
            spi_cs_b_o    <= cs_next;
            spi_dq_o      <= {3'b000, mosi_next};
            spi_dq_oe_o   <= {3'b000, (st_next == BOOTL_CMD)};
            otp_addr_o    <= oa_next;
            otp_rd_o      <= otpv_next;
        end
    end
endmodule // bootl_loader

// >>> test/bootl_loader_sva.sv
`timescale 1ns/100ps
module bootl_loader_chk
    import bootl_pkg::*;
#(
    parameter int ADDR_W    = 15,
    parameter int DELAY_CYC = 375
) (
    input wire logic              clk_i,         // Clock
    input wire logic              rst_b_i,       // Reset pin
    input wire logic [31:0]       security_i,    // Security value
    input wire logic              otp_rd_o,      // OTP strobe
    input wire logic              spi_cs_b_o,    // Flash select
    input wire logic [3:0]        spi_dq_oe_o,   // Flash enables
    input wire logic              ram_we_o,      // RAM strobe
    input wire logic [ADDR_W+1:0] ram_addr_o,    // RAM address
    input wire logic              core_rst_o,    // Tile held
    input wire logic              io_pulldown_o, // Pull-downs
    input wire logic              run_o,         // Started
    input wire logic [ADDR_W+1:0] start_addr_o,  // Start address
    input wire logic              boot_fail_o    // Failure flag
);
    logic              seen_reg, seen_next;
    logic [ADDR_W+1:0] last_reg, last_next;
    // Tracks the last RAM byte address since reset
    always_comb begin
        seen_next = rst_b_i & (seen_reg | ram_we_o);
        last_next = ram_we_o ? ram_addr_o : last_reg;
    end
    always_ff @(posedge clk_i) begin
        seen_reg <= seen_next;
        last_reg <= last_next;
    end
    default clocking cb @(posedge clk_i); endclocking
    sequence s_held; !rst_b_i [*4]; endsequence
    sequence s_booted; rst_b_i && $rose(run_o); endsequence
    chk_reset_hold: assert property (s_held |-> core_rst_o && io_pulldown_o && spi_cs_b_o)
        else $error("reset state not held");
    chk_boot_delay: assert property ($rose(rst_b_i) |-> (spi_cs_b_o && !otp_rd_o) [*4])
        else $error("boot began too early");
    chk_boot_begins: assert property (disable iff (!rst_b_i)
        $rose(rst_b_i) |-> ##[1:40] (!spi_cs_b_o || otp_rd_o)) else $error("boot never began");
    chk_source_otp: assert property (disable iff (!rst_b_i)
        otp_rd_o |-> security_i[5] && spi_cs_b_o) else $error("wrong boot source");
    chk_flash_frame: assert property (disable iff (!rst_b_i)
        !spi_cs_b_o |-> !security_i[5] && !spi_dq_oe_o[1]) else $error("bad flash frame");
    chk_ram_order: assert property (disable iff (!rst_b_i)
        ram_we_o |-> ram_addr_o == (seen_reg ? last_reg + 1'b1 : '0)) else $error("ram order");
    chk_start_addr: assert property (disable iff (!rst_b_i)
        s_booted |-> start_addr_o == '0 && !core_rst_o && !boot_fail_o) else $error("bad start");
    chk_fail_block: assert property (disable iff (!rst_b_i)
        boot_fail_o |-> !run_o ##1 boot_fail_o) else $error("failure not held");
    chk_load_window: assert property (disable iff (!rst_b_i)
        ram_we_o |-> core_rst_o && !run_o && !boot_fail_o) else $error("write after load");
endmodule // bootl_loader_chk

bind bootl_loader bootl_loader_chk #(.ADDR_W(ADDR_W), .DELAY_CYC(DELAY_CYC)) u_chk (.clk_i,
    .rst_b_i, .security_i, .otp_rd_o, .spi_cs_b_o, .spi_dq_oe_o, .ram_we_o, .ram_addr_o,
    .core_rst_o, .io_pulldown_o, .run_o, .start_addr_o, .boot_fail_o);

// >>> test/bootl_flash_model.sv
`timescale 1ns/100ps
module bootl_flash_model (
    input  wire logic       sck_i,  // Serial clock
    input  wire logic       cs_b_i, // Select, active low
    input  wire logic [3:0] dq_i,   // Lines from loader
    output logic      [3:0] dq_o    // Lines to loader
);
    logic [7:0]  mem [0:63]; // Image bytes
    logic [31:0] cmd;        // Command and address
    int          nbit = 99;  // Bits clocked in frame
    logic        q = 1'b0;   // Serial out level
    // Frame start clears the count
    always @(negedge cs_b_i) nbit = 0;
    // Command and address shift in on rising edges
    always @(posedge sck_i) if (!cs_b_i) begin
        if (nbit < 32) cmd = {cmd[30:0], dq_i[0]};
        nbit++;
    end
    // Data MSB first, changed on falling edges
    always @(negedge sck_i) if (!cs_b_i && nbit >= 32) q = mem[(nbit-32)/8][7-(nbit-32)%8];
    // Released line shows the opposite level
    always @(posedge cs_b_i) q = ~q;
    assign dq_o = {~q, ~q, q, ~q};
endmodule // bootl_flash_model

// >>> test/bootl_loader_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module bootl_loader_tb;
    import bootl_pkg::*;
    logic        clk_i = 0, rst_b_i = 0, otp_rd_o, spi_sck_o, spi_cs_b_o, ram_we_o;
    logic        core_rst_o, io_pulldown_o, run_o, boot_fail_o;
    logic [31:0] security_i = '0, otp_data_i = '0;
    logic [14:0] otp_addr_o;
    logic [3:0]  spi_dq_o, spi_dq_oe_o, dq_pin, mdq;
    logic [16:0] ram_addr_o, start_addr_o;
    logic [7:0]  ram_data_o, img[$], got[$];
    int          bad_count = 0, n_compared = 0;
    bootl_loader #(.DELAY_CYC(4)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .security_i(security_i),
        .otp_data_i(otp_data_i), .otp_addr_o(otp_addr_o), .otp_rd_o(otp_rd_o),
        .spi_sck_o(spi_sck_o), .spi_cs_b_o(spi_cs_b_o), .spi_dq_o(spi_dq_o),
        .spi_dq_oe_o(spi_dq_oe_o), .spi_dq_i(dq_pin), .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o), .ram_data_o(ram_data_o), .core_rst_o(core_rst_o),
        .io_pulldown_o(io_pulldown_o), .run_o(run_o), .start_addr_o(start_addr_o),
        .boot_fail_o(boot_fail_o));
    bootl_flash_model flash (.sck_i(spi_sck_o), .cs_b_i(spi_cs_b_o), .dq_i(dq_pin), .dq_o(mdq));
    assign dq_pin = (spi_dq_oe_o & spi_dq_o) | (~spi_dq_oe_o & mdq);
    // Clock and watchdog
    initial forever #20 clk_i = ~clk_i;
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        tally_and_finish();
    end
    // OTP answers with the image word, low byte first
    always @(negedge clk_i) if (otp_rd_o && 4*otp_addr_o+3 < img.size()) otp_data_i <= {
        img[4*otp_addr_o+3],
        img[4*otp_addr_o+2], img[4*otp_addr_o+1], img[4*otp_addr_o]};
    // Every RAM write lands on the next byte address
    always @(posedge clk_i) if (ram_we_o) begin
        `CHK("ram addr", 17'(got.size()), ram_addr_o)
        got.push_back(ram_data_o);
    end
    // Image: length, program, then CRC, skip word or bad CRC
    task build(input int s, input int mode);
        logic [31:0] c;
        img = {};
        for (int i = 0; i < 4; i++) img.push_back(8'(s >> 8*i));
        for (int i = 0; i < 4*s; i++) img.push_back(8'(8'h5A ^ i*7));
        c = 32'hFFFF_FFFF;
        foreach (img[i]) begin
            c = c ^ img[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
        end
        c = (mode == 1) ? 32'h0D15_AB1E : (mode == 2) ? c : ~c;
        for (int i = 0; i < 4; i++) img.push_back(8'(c >> 8*i));
    endtask
    task run_boot(input logic sec);
        security_i[5] = sec;
        foreach (img[i]) flash.mem[i] = img[i];
        rst_b_i = 0;
        repeat (4) @(negedge clk_i);
        got = {};
        flash.nbit = 99;
        rst_b_i = 1;
        for (int i = 0; i < 3000 && run_o !== 1'b1 && boot_fail_o !== 1'b1; i++) @(negedge clk_i);
    endtask
    task chk_prog(input int s, input logic r);
        `CHK("run", r, run_o)
        `CHK("fail", !r, boot_fail_o)
        `CHK("core held", !r, core_rst_o)
        `CHK("pulldown", 1'b0, io_pulldown_o)
        `CHK("byte count", 4*s, got.size())
        foreach (got[i]) `CHK("ram byte", img[4+i], got[i])
    endtask
    task t_reset;
        `CHK("held", 3'b111, {core_rst_o, io_pulldown_o, spi_cs_b_o})
        `CHK("run", 1'b0, run_o)
        $display("test reset done");
    endtask
    task t_crc_ok;
        build(2, 0);
        run_boot(0);
        chk_prog(2, 1);
        `CHK("flash cmd", 32'h0300_0000, flash.cmd)
        `CHK("start", 17'h0_0000, start_addr_o)
        $display("test crc ok done");
    endtask
    task t_skip;
        build(0, 1);
        run_boot(0);
        chk_prog(0, 1);
        $display("test skip done");
    endtask
    task t_bad;
        build(1, 2);
        run_boot(0);
        chk_prog(1, 0);
        $display("test bad crc done");
    endtask
    task t_otp;
        build(3, 1);
        run_boot(1);
        chk_prog(3, 1);
        `CHK("flash idle", 99, flash.nbit)
        $display("test otp done");
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_i);
        t_reset();
        t_crc_ok();
        t_skip();
        t_bad();
        t_otp();
        tally_and_finish();
    end
endmodule // bootl_loader_tb
